// ---- logic/tccp_timer.sv ----
// Overview of operation
// RL1: compare A match raises interrupt A
// RL2: compare B match raises interrupt B, no clear
// RL3: capture A loads on trigger A or B
// RL4: capture B loads only on trigger A edge
// RL5: trigger B detection disables the output pin
// RL6: free-running mode counts up every tick
// RL7: overflow flag set when wrapping from ffff
// RL8: overflow flag held until software writes zero
// RL9: output toggles on every compare match outside pulse mode
// RL10: trigger A edge captures B, raises interrupt
// RL11: both capture: no toggle without edge toggle
// RL12: edge toggle bit toggles output on trigger A
// RL13: only trigger B enabled: B never captures
// RL14: pulse mode clears counter on match A
// RL15: pulse period is compare A plus one
// RL16: active width is compare B plus one
// RL17: counter read leaves counting undisturbed
// RL18: edge clear mode restarts counter on trigger A
// RL19: reverse phase captures A without interrupt A
// RL20: stop mode holds counter at zero
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`include "tccp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tccp_timer (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire tccp_pkg::tccp_addr_t s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire tccp_pkg::tccp_word_t s_axi_wdata,
    input  wire tccp_pkg::tccp_strb_t s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output tccp_pkg::tccp_resp_t      s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire tccp_pkg::tccp_addr_t s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output tccp_pkg::tccp_word_t      s_axi_rdata,
    output tccp_pkg::tccp_resp_t      s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 trigger_input_a,
    input  wire logic                 trigger_input_b,
    output logic                      timer_output_pin,
    output logic                      match_a_interrupt,
    output logic                      match_b_interrupt
);
    import tccp_pkg::*;

    // state and next count; all but the next count, tick divider and output level are bus readable
    logic [15:0] counter_value_reg;          // running count
    logic [15:0] counter_value_next;         // count for next edge
    logic [15:0] capture_compare_a_reg;      // compare or capture A
    logic [15:0] capture_compare_b_reg;      // compare or capture B
    logic [7:0]  prescaler_edge_select_reg;  // edge selects and tick rate
    logic [3:0]  mode_control_reg;           // mode, edge toggle, overflow
    logic [2:0]  capture_control_reg;        // capture use and reverse phase
    logic        output_enable_reg;          // timer output enable
    logic [2:0]  prescale_reg;               // tick divider
    logic        out_level_reg;              // output level

    // decoded controls
    tccp_mode_t  op_mode;           // operating mode
    tccp_edge_t  input_a_edge_sel;  // valid edge of trigger A
    tccp_edge_t  input_b_edge_sel;  // valid edge of trigger B
    logic [1:0]  count_clock_sel;   // tick divider select
    logic [2:0]  prescale_mask;     // divider bits that must be all ones
    logic        run;               // counter active
    logic        tick;              // count clock enable
    logic        cap_a_mode;        // A used for capture
    logic        cap_b_mode;        // B used for capture
    logic        reverse_phase_capture_select;
    logic        output_on_edge_toggle;
    logic        overflow_flag;
    logic        out_avail;         // output pin usable

    // event terms
    logic        edge_a_raw;        // valid edge on trigger A
    logic        edge_b_raw;        // valid edge on trigger B
    logic        opp_a_raw;         // opposite edge on trigger A
    logic        edge_a;            // gated by run
    logic        edge_b;
    logic        opp_a;
    logic        match_a;           // compare A hit this tick
    logic        match_b;           // compare B hit this tick
    logic        load_a;            // capture into A
    logic        load_b;            // capture into B
    logic        clear_edge;        // restart on trigger A
    logic        clear_match;       // restart on match A
    logic        overflow_set;      // wrap from top count

    // bus terms
    logic        wr_fire;           // write address and data taken
    logic        rd_fire;           // read address taken
    logic        wr_mapped;         // write hits a register
    logic        mc_wr;             // write to mode control
    tccp_word_t  rd_data;           // read mux

    // merge a half word under its byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    // field decode
    assign op_mode          = tccp_mode_t'(mode_control_reg[`TCCP_MC_MODE_HI:`TCCP_MC_MODE_LO]);
    assign input_a_edge_sel = tccp_edge_t'(prescaler_edge_select_reg[`TCCP_PR_A_HI:`TCCP_PR_A_LO]);
    assign input_b_edge_sel = tccp_edge_t'(prescaler_edge_select_reg[`TCCP_PR_B_HI:`TCCP_PR_B_LO]);
    assign count_clock_sel  = prescaler_edge_select_reg[`TCCP_PR_CLK_HI:`TCCP_PR_CLK_LO];
    assign cap_a_mode       = capture_control_reg[`TCCP_CC_CAP_A];
    assign cap_b_mode       = capture_control_reg[`TCCP_CC_CAP_B];
    assign reverse_phase_capture_select = capture_control_reg[`TCCP_CC_REVERSE];
    assign output_on_edge_toggle        = mode_control_reg[`TCCP_MC_EDGE_TGL];
    assign overflow_flag    = mode_control_reg[`TCCP_MC_OVF];
    assign run              = (op_mode != MODE_STOP);

    // trigger edge detectors
    tccp_edge_detect u_edge_a (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .sig_in        (trigger_input_a),
        .edge_sel      (input_a_edge_sel),
        .valid_edge    (edge_a_raw),
        .opposite_edge (opp_a_raw)
    );

    tccp_edge_detect u_edge_b (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .sig_in        (trigger_input_b),
        .edge_sel      (input_b_edge_sel),
        .valid_edge    (edge_b_raw),
        .opposite_edge ()
    );

    // prescaler: tick every 1, 2, 4 or 8 aclk cycles
    assign prescale_mask = 3'((4'h1 << count_clock_sel) - 4'h1);
    assign tick          = ((prescale_reg & prescale_mask) == prescale_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_reg <= `TCCP_RST_3;
        end else if (!run) begin
            prescale_reg <= `TCCP_RST_3;   // restart phase on start
        end else begin
            prescale_reg <= prescale_reg + 3'h1;
        end
    end

    // events; nothing happens while stopped
    assign edge_a      = run & edge_a_raw;
    assign edge_b      = run & edge_b_raw;
    assign opp_a       = run & opp_a_raw;
    assign match_a     = run & ~cap_a_mode & tick & (counter_value_reg == capture_compare_a_reg);  // RL1
    assign match_b     = run & ~cap_b_mode & tick & (counter_value_reg == capture_compare_b_reg);  // RL2
    assign load_b      = cap_b_mode & edge_a;  // RL4 RL13
    // source A: trigger B edge, or trigger A opposite edge in reverse phase
    assign load_a      = cap_a_mode & (reverse_phase_capture_select ? opp_a : edge_b);  // RL3 RL19
    assign clear_edge  = (op_mode == MODE_EDGE_CLEAR) & edge_a;  // RL18
    assign clear_match = (op_mode == MODE_PULSE) & match_a;      // RL14 RL15
    assign overflow_set = tick & ~clear_edge & ~clear_match & run
                        & (counter_value_reg == `TCCP_CNT_MAX);  // RL7

    // next count
    always_comb begin
        if (!run) begin
            counter_value_next = `TCCP_CNT_ZERO;   // RL20
        end else if (clear_edge || (tick && clear_match)) begin
            counter_value_next = `TCCP_CNT_ZERO;   // RL14 RL18
        end else if (tick) begin
            counter_value_next = counter_value_reg + `TCCP_CNT_ONE;  // RL6 RL7
        end else begin
            counter_value_next = counter_value_reg;
        end
    end

    // counter register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_value_reg <= `TCCP_RST_16;
        end else begin
            counter_value_reg <= counter_value_next;
        end
    end

    // interrupt pulses, one cycle each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a_interrupt <= 1'b0;
            match_b_interrupt <= 1'b0;
        end else begin
            // trigger B edge flags A in capture mode, even in reverse phase; reverse phase capture does not
            match_a_interrupt <= match_a | (cap_a_mode & edge_b);  // RL1 RL19
            match_b_interrupt <= match_b | load_b;                 // RL2 RL10
        end
    end

    // bus handshakes: write address and data taken together
    assign wr_fire       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid & s_axi_arready;
    assign mc_wr         = wr_fire & (s_axi_awaddr == `TCCP_OFF_MODE_CTRL) & s_axi_wstrb[0];
    assign wr_mapped     = (s_axi_awaddr == `TCCP_OFF_COUNTER) || (s_axi_awaddr == `TCCP_OFF_CC_A)
                        || (s_axi_awaddr == `TCCP_OFF_CC_B) || (s_axi_awaddr == `TCCP_OFF_PRESCALE)
                        || (s_axi_awaddr == `TCCP_OFF_MODE_CTRL) || (s_axi_awaddr == `TCCP_OFF_CAPT_CTRL)
                        || (s_axi_awaddr == `TCCP_OFF_OUT_CTRL);

    // capture registers: a capture wins over a software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_compare_a_reg <= `TCCP_RST_16;
        end else if (load_a) begin
            capture_compare_a_reg <= counter_value_reg;  // RL3 RL19
        end else if (wr_fire && s_axi_awaddr == `TCCP_OFF_CC_A) begin
            capture_compare_a_reg <= merge16(capture_compare_a_reg, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_compare_b_reg <= `TCCP_RST_16;
        end else if (load_b) begin
            capture_compare_b_reg <= counter_value_reg;  // RL4 RL10
        end else if (wr_fire && s_axi_awaddr == `TCCP_OFF_CC_B) begin
            capture_compare_b_reg <= merge16(capture_compare_b_reg, s_axi_wdata[15:0], s_axi_wstrb[1:0]);
        end
    end

    // control registers, one byte lane each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler_edge_select_reg <= `TCCP_RST_8;
            capture_control_reg       <= `TCCP_RST_3;
            output_enable_reg         <= 1'b0;
        end else if (wr_fire && s_axi_wstrb[0]) begin
            if (s_axi_awaddr == `TCCP_OFF_PRESCALE) begin
                prescaler_edge_select_reg <= s_axi_wdata[7:0];
            end
            if (s_axi_awaddr == `TCCP_OFF_CAPT_CTRL) begin
                capture_control_reg <= s_axi_wdata[2:0];
            end
            if (s_axi_awaddr == `TCCP_OFF_OUT_CTRL) begin
                output_enable_reg <= s_axi_wdata[`TCCP_OC_ENABLE];
            end
        end
    end

    // mode control; overflow is cleared by writing zero, and a wrap wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_control_reg <= `TCCP_RST_4;
        end else begin
            if (mc_wr) begin
                mode_control_reg[`TCCP_MC_MODE_HI:`TCCP_MC_EDGE_TGL] <=
                    s_axi_wdata[`TCCP_MC_MODE_HI:`TCCP_MC_EDGE_TGL];
            end
            if (overflow_set) begin
                mode_control_reg[`TCCP_MC_OVF] <= 1'b1;  // RL7
            end else if (mc_wr && !s_axi_wdata[`TCCP_MC_OVF]) begin
                mode_control_reg[`TCCP_MC_OVF] <= 1'b0;  // RL8
            end
        end
    end

    // output level; trigger B detection takes the pin away
    assign out_avail = output_enable_reg & (input_b_edge_sel == EDGE_NONE);  // RL5

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_level_reg <= 1'b0;
        end else if (!out_avail) begin
            out_level_reg <= 1'b0;  // RL5
        end else if (op_mode == MODE_PULSE) begin
            // active from restart through count B
            if (match_a) begin
                out_level_reg <= 1'b1;  // RL15
            end else if (match_b) begin
                out_level_reg <= 1'b0;  // RL16
            end
        end else if (match_a || match_b || (output_on_edge_toggle && edge_a)) begin
            out_level_reg <= ~out_level_reg;  // RL9 RL11 RL12
        end
    end

    assign timer_output_pin = out_level_reg;

    // read mux; counter read has no side effect
    always_comb begin
        case (s_axi_araddr)
            `TCCP_OFF_COUNTER:   rd_data = {16'h0000, counter_value_reg};  // RL17
            `TCCP_OFF_CC_A:      rd_data = {16'h0000, capture_compare_a_reg};
            `TCCP_OFF_CC_B:      rd_data = {16'h0000, capture_compare_b_reg};
            `TCCP_OFF_PRESCALE:  rd_data = {24'h000000, prescaler_edge_select_reg};
            `TCCP_OFF_MODE_CTRL: rd_data = {28'h0000000, mode_control_reg};
            `TCCP_OFF_CAPT_CTRL: rd_data = {29'h00000000, capture_control_reg};
            `TCCP_OFF_OUT_CTRL:  rd_data = {31'h00000000, output_enable_reg};
            default:             rd_data = `TCCP_WORD_ZERO;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `TCCP_WORD_ZERO;
            s_axi_rresp  <= `TCCP_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= (s_axi_araddr[7:2] <= 6'h06 && s_axi_araddr[1:0] == 2'h0) ? `TCCP_RESP_OKAY
                                                                                     : `TCCP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // write response channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TCCP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `TCCP_RESP_OKAY : `TCCP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_free_count_step: assert property ((op_mode == MODE_FREE) && tick  // RL6
        |=> counter_value_reg == $past(counter_value_reg) + `TCCP_CNT_ONE)
        else $error("free count did not step by one");
    a_overflow_wrap: assert property ((op_mode == MODE_FREE) && tick  // RL7
        && counter_value_reg == `TCCP_CNT_MAX |=> overflow_flag && counter_value_reg == `TCCP_CNT_ZERO)
        else $error("wrap did not set overflow");
    a_overflow_held: assert property (overflow_flag && !(mc_wr && !s_axi_wdata[`TCCP_MC_OVF])  // RL8
        |=> overflow_flag)
        else $error("overflow dropped without write");
    a_match_a_irq: assert property (run && !cap_a_mode && tick  // RL1
        && counter_value_reg == capture_compare_a_reg |=> match_a_interrupt)
        else $error("compare A match gave no interrupt");
    a_match_b_keep: assert property ((op_mode == MODE_FREE) && !cap_b_mode && tick  // RL2
        && counter_value_reg == capture_compare_b_reg && counter_value_reg != `TCCP_CNT_MAX
        |=> match_b_interrupt && counter_value_reg == $past(counter_value_reg) + `TCCP_CNT_ONE)
        else $error("compare B match wrong");
    a_pulse_restart: assert property ((op_mode == MODE_PULSE) && match_a  // RL14
        |=> counter_value_reg == `TCCP_CNT_ZERO)
        else $error("pulse mode did not restart");
    a_pulse_active: assert property ((op_mode == MODE_PULSE) && out_avail && match_a  // RL15
        |=> timer_output_pin)
        else $error("pulse did not go active");
    a_pulse_inactive: assert property ((op_mode == MODE_PULSE) && out_avail && match_b && !match_a  // RL16
        |=> !timer_output_pin)
        else $error("pulse did not end at B");
    a_capture_b_load: assert property (load_b  // RL4
        |=> capture_compare_b_reg == $past(counter_value_reg) && match_b_interrupt)
        else $error("B capture wrong");
    a_reverse_no_irq: assert property (load_a && reverse_phase_capture_select && !edge_b && !match_a  // RL19
        |=> capture_compare_a_reg == $past(counter_value_reg) && !match_a_interrupt)
        else $error("reverse capture wrong");
    a_pin_blocked: assert property (input_b_edge_sel != EDGE_NONE |=> !timer_output_pin)  // RL5
        else $error("pin driven while trigger B detected");
    a_stop_zero: assert property (op_mode == MODE_STOP  // RL20
        |=> counter_value_reg == `TCCP_CNT_ZERO && !match_a_interrupt && !match_b_interrupt)
        else $error("stopped counter not idle");
    a_edge_restart: assert property ((op_mode == MODE_EDGE_CLEAR) && edge_a  // RL18
        |=> counter_value_reg == `TCCP_CNT_ZERO)
        else $error("trigger A did not restart");
    a_edge_toggle: assert property (out_avail && op_mode != MODE_PULSE && output_on_edge_toggle  // RL12
        && edge_a && !match_a && !match_b |=> timer_output_pin != $past(timer_output_pin))
        else $error("edge toggle missing");

endmodule

`default_nettype wire

// ---- logic/tccp_defines.svh ----
`ifndef TCCP_DEFINES_SVH
`define TCCP_DEFINES_SVH

// register byte offsets
`define TCCP_OFF_COUNTER      8'h00
`define TCCP_OFF_CC_A         8'h04
`define TCCP_OFF_CC_B         8'h08
`define TCCP_OFF_PRESCALE     8'h0c
`define TCCP_OFF_MODE_CTRL    8'h10
`define TCCP_OFF_CAPT_CTRL    8'h14
`define TCCP_OFF_OUT_CTRL     8'h18

// mode control fields
`define TCCP_MC_OVF           0
`define TCCP_MC_EDGE_TGL      1
`define TCCP_MC_MODE_LO       2
`define TCCP_MC_MODE_HI       3

// capture control fields
`define TCCP_CC_CAP_A         0
`define TCCP_CC_REVERSE       1
`define TCCP_CC_CAP_B         2

// output control fields
`define TCCP_OC_ENABLE        0

// prescaler and edge select fields
`define TCCP_PR_CLK_LO        0
`define TCCP_PR_CLK_HI        1
`define TCCP_PR_A_LO          4
`define TCCP_PR_A_HI          5
`define TCCP_PR_B_LO          6
`define TCCP_PR_B_HI          7

// reset values and counter limits
`define TCCP_RST_16           16'h0000
`define TCCP_RST_8            8'h00
`define TCCP_RST_4            4'h0
`define TCCP_RST_3            3'h0
`define TCCP_CNT_ZERO         16'h0000
`define TCCP_CNT_ONE          16'h0001
`define TCCP_CNT_MAX          16'hffff

// bus answers
`define TCCP_RESP_OKAY        2'h0
`define TCCP_RESP_SLVERR      2'h2
`define TCCP_WORD_ZERO        32'h0000_0000

`endif

// ---- logic/tccp_pkg.sv ----
`default_nettype none

package tccp_pkg;

    // bus carriers
    typedef logic [7:0]  tccp_addr_t;
    typedef logic [31:0] tccp_word_t;
    typedef logic [3:0]  tccp_strb_t;
    typedef logic [1:0]  tccp_resp_t;

    // operating mode codes
    typedef enum logic [1:0] {
        MODE_STOP       = 2'h0,
        MODE_FREE       = 2'h1,
        MODE_EDGE_CLEAR = 2'h2,
        MODE_PULSE      = 2'h3
    } tccp_mode_t;

    // trigger edge select codes
    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_NONE = 2'h2,
        EDGE_BOTH = 2'h3
    } tccp_edge_t;

endpackage

`default_nettype wire

// ---- logic/tccp_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

module tccp_edge_detect (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 sig_in,
    input  wire tccp_pkg::tccp_edge_t edge_sel,
    output logic                      valid_edge,
    output logic                      opposite_edge
);
    import tccp_pkg::*;

    logic prev_reg;   // last sampled pin level
    logic rise;       // low to high this cycle
    logic fall;       // high to low this cycle

    // remember the pin level of the previous cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sig_in;
        end
    end

    assign rise = sig_in & ~prev_reg;
    assign fall = ~sig_in & prev_reg;

    // pick the valid edge and its opposite phase
    always_comb begin
        valid_edge    = 1'b0;
        opposite_edge = 1'b0;
        case (edge_sel)
            EDGE_FALL: begin
                valid_edge    = fall;
                opposite_edge = rise;
            end
            EDGE_RISE: begin
                valid_edge    = rise;
                opposite_edge = fall;
            end
            EDGE_BOTH: begin
                valid_edge    = rise | fall;
            end
            default: begin
                valid_edge    = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- bench/tccp_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none
// far side: drives both trigger pins and counts output pin changes
module tccp_far_side (
    input  wire logic aclk,
    output logic      trig_a,
    output logic      trig_b,
    input  wire logic out_pin,
    output int        toggles
);
    logic last_pin;
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
        last_pin = 1'b0;
        toggles = 0;
    end
    // every level change of the output pin is one toggle
    always @(posedge aclk) begin
        last_pin <= out_pin;
        if (out_pin !== last_pin) toggles <= toggles + 1;
    end
    // one edge on a pin, then held so the sampler sees it settle
    task automatic flip(input bit pin_b);
        @(posedge aclk);
        if (pin_b) trig_b <= ~trig_b;
        else trig_a <= ~trig_a;
        repeat (4) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// ---- bench/timer16_capture_compare_ppg_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_ppg_bench;
    import tccp_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic trigger_input_a, trigger_input_b, timer_output_pin, match_a_interrupt, match_b_interrupt;
    tccp_addr_t s_axi_awaddr, s_axi_araddr;
    tccp_word_t s_axi_wdata, s_axi_rdata, v, c0, c1;
    tccp_strb_t s_axi_wstrb;
    tccp_resp_t s_axi_bresp, s_axi_rresp, r;
    int error_cnt = 0, checked = 0, cyc = 0, na = 0, nb = 0, ka, kb, kt, tg, m, n, h, p;
    tccp_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .trigger_input_a, .trigger_input_b, .timer_output_pin, .match_a_interrupt,
        .match_b_interrupt);
    tccp_far_side i_far (.aclk, .trig_a(trigger_input_a), .trig_b(trigger_input_b),
        .out_pin(timer_output_pin), .toggles(tg));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // count interrupt pulses; cut a hang short
    always @(posedge aclk) begin
        na <= na + (match_a_interrupt === 1'b1);
        nb <= nb + (match_b_interrupt === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic check(input tccp_word_t got, input tccp_word_t exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bus write: address and data offered together, held until taken
    task automatic wr(input tccp_addr_t a, input tccp_word_t d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    endtask
    // bus read: data and response taken at the edge that shows rvalid
    task automatic rd(input tccp_addr_t a, output tccp_word_t d, output tccp_resp_t rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wdata, s_axi_wstrb} = {2'h3, 32'h0, 4'hf};
        v = $urandom(32'h5e45);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, v, r);
        check(v, 0);
        rd(8'h40, v, r);
        check(r, 2'h2);
        // two compares in free-running mode over one full wrap
        c0 = $urandom & 32'hffff;
        c1 = c0 ^ 32'h0100;
        wr(8'h04, c0);
        wr(8'h08, c1);
        rd(8'h08, v, r);
        check(v, c1);
        wr(8'h0c, 8'h80);
        wr(8'h18, 1);
        wr(8'h10, 8'h04);
        rd(8'h00, c0, r);
        rd(8'h00, c1, r);
        check(c1 - c0 < 8 && c1 > c0, 1);
        {ka, kb, kt} = {na, nb, tg};
        repeat (65536) @(posedge aclk);
        check(na - ka, 1);
        check(nb - kb, 1);
        check(tg - kt, 2);
        rd(8'h10, v, r);
        check(v, 8'h05);
        wr(8'h10, 8'h04);
        rd(8'h10, v, r);
        check(v, 8'h04);
        // both capture, rising trigger A, edge toggle on
        wr(8'h14, 8'h05);
        wr(8'h0c, 8'h90);
        wr(8'h10, 8'h06);
        {kb, kt} = {nb, tg};
        rd(8'h00, c0, r);
        i_far.flip(0);
        rd(8'h08, v, r);
        rd(8'h00, c1, r);
        check(v > c0 && v < c1, 1);
        i_far.flip(0);
        i_far.flip(1);
        check(nb - kb, 1);
        check(tg - kt, 1);
        // pulse mode with random period and width
        wr(8'h14, 0);
        wr(8'h0c, 8'h80);
        for (int k = 0; k < 3; k++) begin
            m = $urandom_range(40, 2);
            n = $urandom_range(m - 1, 0);
            wr(8'h10, 0);
            wr(8'h04, m);
            wr(8'h08, n);
            wr(8'h10, 8'h0c);
            while (timer_output_pin !== 1'b0) @(posedge aclk);
            while (timer_output_pin !== 1'b1) @(posedge aclk);
            for (h = 0; timer_output_pin === 1'b1; h++) @(posedge aclk);
            for (p = h; timer_output_pin !== 1'b1; p++) @(posedge aclk);
            check(h, n + 1);
            check(p, m + 1);
        end
        // restart on trigger A edge; B keeps the count
        wr(8'h14, 8'h04);
        wr(8'h0c, 8'h90);
        wr(8'h10, 8'h08);
        repeat (200) @(posedge aclk);
        i_far.flip(0);
        rd(8'h00, c0, r);
        rd(8'h08, v, r);
        check(v >= 200 && c0 < 8, 1);
        // trigger B only: loads A, never B, pin taken away
        wr(8'h14, 8'h05);
        wr(8'h0c, 8'he0);
        rd(8'h08, c1, r);
        rd(8'h00, c0, r);
        {ka, kb} = {na, nb};
        i_far.flip(1);
        i_far.flip(0);
        rd(8'h04, v, r);
        check(v > c0 && v < c0 + 16, 1);
        check(na - ka, 1);
        check(nb - kb, 0);
        rd(8'h08, v, r);
        check(v, c1);
        repeat (3) @(posedge aclk);
        for (int k = 0; k < m + 2; k++) begin
            @(posedge aclk);
            check(timer_output_pin, 0);
        end
        final_report();
    end
endmodule
`default_nettype wire
